// *** servo_status_pkg.sv ***
// Purpose: constants for the servo status output block
// Assumes: 125 MHz pclk, APB register access
// Notes: alarm numbers are 8-bit hex codes of the alarm display
package servo_status_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STATE = 8'h08;
  localparam logic [7:0] OFF_SPEED = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_OUTS = 8'h18;
  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTRL_SERVO_ON = 0;
  localparam int CTRL_POS_MODE = 1;
  localparam int CTRL_BRAKE_SEL = 2;
  localparam int CTRL_WARN_EN = 3;
  localparam int CTRL_CODE_EN = 4;
  localparam int CTRL_ALARM_RST = 5;
  localparam int CTRL_WARN_PIN_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Warning output pin selection
  localparam logic [1:0] WPIN_READY = 2'h0;
  localparam logic [1:0] WPIN_INPOS = 2'h1;
  localparam logic [1:0] WPIN_SPEED = 2'h2;
  localparam logic [1:0] WPIN_ZERO = 2'h3;
  // ****************************************
  // Config register fields, defaults and fixed speed-reached limits
  // ****************************************
  localparam int CFG_INPOS_LSB = 0;
  localparam int CFG_ZERO_LSB = 16;
  localparam logic [15:0] INPOS_RESET = 16'h0064;
  localparam logic [15:0] ZERO_SPEED_RPM = 16'h0032;
  localparam logic [15:0] REACH_HOLD_RPM = 16'h0032;
  localparam logic [15:0] REACH_TOL_RPM = 16'h000A;
  // ****************************************
  // Interrupt status bits
  // ****************************************
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_WARN = 1;
  localparam int IRQ_READY = 2;
  localparam int IRQ_W = 3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int STARTUP_MS = 1000;
  localparam int STARTUP_CYC = STARTUP_MS * CLK_MHZ * 1000;
endpackage

// *** alarm_code_map.sv ***
// Purpose: map an alarm number to its 3-bit group code
// Assumes: alarm number is the two hex digits of the display
// Notes: unknown alarms fall in the all-open group
`timescale 1ns/1ps
module alarm_code_map
(
  input wire logic [7:0] alarm_num,
  output logic [2:0] group_code
);
  always_comb
  begin
    unique case (alarm_num)
      8'h10: group_code = 3'h2;
      8'h30, 8'h33: group_code = 3'h1;
      8'h45, 8'h46: group_code = 3'h3;
      8'h50, 8'h51: group_code = 3'h6;
      8'h24, 8'h32: group_code = 3'h4;
      8'h31, 8'h35, 8'h52: group_code = 3'h5;
      8'h16, 8'h1A, 8'h20: group_code = 3'h3;
      default: group_code = 3'h0;
    endcase
  end
endmodule

// *** sync2.sv ***
// Purpose: two-flop synchroniser for pin levels
// Assumes: single clock domain on the reader side
// Notes: stage one feeds stage two only
`timescale 1ns/1ps
module sync2 #(parameter int W = 1)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else if (en)
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// *** servo_status_outputs.sv ***
// Purpose: discrete status contacts of a servo amplifier, APB programmable
// Assumes: power stage and alarm/warning sources are asynchronous pin levels
// Notes: 1 on an output means contact closed
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Trouble opens on power off or shutdown
// - Trouble closes one second after power-on
// - Ready closes when servo on and able
// - In-position closes when droop within range
// - Speed reached near preset, held at low
// - Zero speed closes at or below threshold
// - Brake select copies interlock to zero pin
// - Brake interlock opens on servo off, alarm
// - Warning closes on warning, pin assigned
// - Warning opens within one second startup
// - Alarm code replaces ordinary signals on alarm
module servo_status_outputs #(
  parameter int STARTUP_CYC = servo_status_pkg::STARTUP_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_ok,
  input wire logic base_shutoff,
  input wire logic alarm_active,
  input wire logic [7:0] alarm_num,
  input wire logic warning_active,
  input wire logic [15:0] droop_abs,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] preset_speed,
  output logic trouble_out,
  output logic ready_out,
  output logic in_position_out,
  output logic speed_reached_out,
  output logic zero_speed_out,
  output logic brake_interlock_out,
  output logic warning_out,
  output logic alarm_group_bit0,
  output logic alarm_group_bit1,
  output logic alarm_group_bit2,
  output logic irq
);
  // ****************************************
  // Pin input synchronisation
  // ****************************************
  logic [3:0] pin_s;
  logic [7:0] alarm_num_s;
  logic [47:0] meas_s;
  logic power_ok_s;
  logic base_off_s;
  logic alarm_s;
  logic warn_s;
  logic [15:0] droop_s;
  logic [15:0] speed_s;
  logic [15:0] preset_s;

  sync2 #(.W(4)) u_sync_pins
  (
    .pclk(pclk),
    .presetn(presetn),
    .en(clk_en),
    .d({power_ok, base_shutoff, alarm_active, warning_active}),
    .q(pin_s)
  );
  // Multi-bit values are assumed slow against pclk; a torn sample lasts one cycle
  sync2 #(.W(56)) u_sync_meas
  (
    .pclk(pclk),
    .presetn(presetn),
    .en(clk_en),
    .d({alarm_num, droop_abs, motor_speed, preset_speed}),
    .q({alarm_num_s, meas_s})
  );
  assign {power_ok_s, base_off_s, alarm_s, warn_s} = pin_s;
  assign {droop_s, speed_s, preset_s} = meas_s;

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl_r;
  logic [15:0] inpos_r;
  logic [15:0] zero_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [31:0] cnt_r;
  logic started_r;
  logic [2:0] code_r;
  logic code_valid_r;
  logic alarm_d_r;
  logic warn_d_r;
  logic ready_d_r;
  logic [2:0] group_code;
  logic wr;
  logic rd;
  logic servo_on;
  logic pos_mode;
  logic brake_sel;
  logic warn_en;
  logic code_en;
  logic [1:0] warn_pin;
  logic able;
  logic ready_nxt;
  logic inpos_nxt;
  logic reach_nxt;
  logic zero_nxt;
  logic brake_nxt;
  logic code_hold;
  logic [15:0] speed_diff;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign servo_on = ctrl_r[servo_status_pkg::CTRL_SERVO_ON];
  assign pos_mode = ctrl_r[servo_status_pkg::CTRL_POS_MODE];
  assign brake_sel = ctrl_r[servo_status_pkg::CTRL_BRAKE_SEL];
  assign warn_en = ctrl_r[servo_status_pkg::CTRL_WARN_EN];
  assign code_en = ctrl_r[servo_status_pkg::CTRL_CODE_EN];
  assign warn_pin = ctrl_r[servo_status_pkg::CTRL_WARN_PIN_LSB +: 2];

  alarm_code_map u_map
  (
    .alarm_num(alarm_num_s),
    .group_code(group_code)
  );

  // ****************************************
  // APB slave, zero wait states
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= servo_status_pkg::CTRL_RESET;
      inpos_r <= servo_status_pkg::INPOS_RESET;
      zero_r <= servo_status_pkg::ZERO_SPEED_RPM;
      irq_mask_r <= '0;
    end
    else if (clk_en && wr)
    begin
      unique case (paddr)
        servo_status_pkg::OFF_CTRL: ctrl_r <= {22'h0, pwdata[9:8], 2'h0, pwdata[5:0]};
        servo_status_pkg::OFF_CFG:
        begin
          inpos_r <= pwdata[servo_status_pkg::CFG_INPOS_LSB +: 16];
          zero_r <= pwdata[servo_status_pkg::CFG_ZERO_LSB +: 16];
        end
        servo_status_pkg::OFF_IRQ_MASK: irq_mask_r <= pwdata[2:0];
        default: ;
      endcase
    end
    else if (clk_en)
      ctrl_r[servo_status_pkg::CTRL_ALARM_RST] <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= psel && !penable;
      // Unmapped or unaligned offsets answer with an error and drop writes
      pslverr <= psel && !penable && (paddr[1:0] != 2'h0 || paddr > servo_status_pkg::OFF_OUTS);
      // Read data latched at setup so it stands through the access cycle
      if (rd)
      begin
        unique case (paddr)
          servo_status_pkg::OFF_CTRL: prdata <= ctrl_r;
          servo_status_pkg::OFF_CFG: prdata <= {zero_r, inpos_r};
          servo_status_pkg::OFF_STATE:
            prdata <= {20'h0, code_valid_r, code_r, started_r, power_ok_s,
                       base_off_s, alarm_s, warn_s, alarm_num_s[2:0]};
          servo_status_pkg::OFF_SPEED: prdata <= {speed_s, droop_s};
          servo_status_pkg::OFF_IRQ_STAT: prdata <= {29'h0, irq_stat_r};
          servo_status_pkg::OFF_IRQ_MASK: prdata <= {29'h0, irq_mask_r};
          servo_status_pkg::OFF_OUTS:
            prdata <= {21'h0, irq, alarm_group_bit2, alarm_group_bit1, alarm_group_bit0,
                       warning_out, brake_interlock_out, zero_speed_out,
                       speed_reached_out, in_position_out, ready_out, trouble_out};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // Startup timer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 32'h0000_0000;
      started_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!power_ok_s)
      begin
        cnt_r <= 32'h0000_0000;
        started_r <= 1'b0;
      end
      else if (!started_r)
      begin
        cnt_r <= cnt_r + 32'h0000_0001;
        // Finishes before the full second so outputs settle inside it
        if (cnt_r >= 32'(STARTUP_CYC - 2))
          started_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // Alarm code latch
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_r <= 3'h0;
      code_valid_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (alarm_s && !code_valid_r)
      begin
        code_r <= group_code;
        code_valid_r <= 1'b1;
      end
      // Reset is ignored while the alarm pin is still high
      else if (!alarm_s && ctrl_r[servo_status_pkg::CTRL_ALARM_RST])
        code_valid_r <= 1'b0;
    end
  end

  // ****************************************
  // Ordinary signal decode
  // ****************************************
  assign able = power_ok_s && started_r && !base_off_s && !code_valid_r && !alarm_s;
  assign speed_diff = (speed_s > preset_s) ? speed_s - preset_s : preset_s - speed_s;
  assign ready_nxt = servo_on && able;
  assign inpos_nxt = pos_mode && ready_nxt && droop_s <= inpos_r;
  assign reach_nxt = !pos_mode && ready_nxt &&
                     (preset_s <= servo_status_pkg::REACH_HOLD_RPM ||
                      speed_diff <= servo_status_pkg::REACH_TOL_RPM);
  assign zero_nxt = started_r && speed_s <= zero_r;
  assign brake_nxt = servo_on && !alarm_s && !code_valid_r;
  assign code_hold = code_en && code_valid_r;

  // ****************************************
  // Shared pin ownership
  // ****************************************
  // Alarm code takes the ordinary pins over while latched; warning takes its selected pin while enabled
  function automatic logic pin_free(input logic code_on, input logic warn_on,
                                    input logic [1:0] sel, input logic [1:0] own);
    pin_free = !code_on && !(warn_on && sel == own);
  endfunction

  // ****************************************
  // Output contacts
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trouble_out <= 1'b0;
      ready_out <= 1'b0;
      in_position_out <= 1'b0;
      speed_reached_out <= 1'b0;
      zero_speed_out <= 1'b0;
      brake_interlock_out <= 1'b0;
      warning_out <= 1'b0;
      alarm_group_bit0 <= 1'b0;
      alarm_group_bit1 <= 1'b0;
      alarm_group_bit2 <= 1'b0;
    end
    else if (clk_en)
    begin
      trouble_out <= power_ok_s && started_r && !base_off_s && !alarm_s && !code_valid_r;
      brake_interlock_out <= brake_nxt;
      warning_out <= started_r && warn_en && warn_s;
      if (code_en)
      begin
        // Code pins carry the latched group on alarm and stay open otherwise
        alarm_group_bit0 <= code_valid_r && code_r[0];
        alarm_group_bit1 <= code_valid_r && code_r[1];
        alarm_group_bit2 <= code_valid_r && code_r[2];
      end
      else
      begin
        alarm_group_bit0 <= 1'b0;
        alarm_group_bit1 <= 1'b0;
        alarm_group_bit2 <= 1'b0;
      end
      ready_out <= ready_nxt && pin_free(code_hold, warn_en, warn_pin,
                                         servo_status_pkg::WPIN_READY);
      in_position_out <= inpos_nxt && pin_free(code_hold, warn_en, warn_pin,
                                               servo_status_pkg::WPIN_INPOS);
      speed_reached_out <= reach_nxt && pin_free(code_hold, warn_en, warn_pin,
                                                 servo_status_pkg::WPIN_SPEED);
      // Brake select takes the zero-speed pin over completely
      zero_speed_out <= brake_sel ? brake_nxt :
                        zero_nxt && pin_free(code_hold, warn_en, warn_pin,
                                             servo_status_pkg::WPIN_ZERO);
    end
  end

  // ****************************************
  // Interrupts: set wins over write-one clear
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alarm_d_r <= 1'b0;
      warn_d_r <= 1'b0;
      ready_d_r <= 1'b0;
      irq_stat_r <= 3'h0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      alarm_d_r <= alarm_s;
      warn_d_r <= warn_s;
      ready_d_r <= ready_nxt;
      // Either direction of ready counts as an event
      irq_stat_r <= (irq_stat_r & ~((wr && paddr == servo_status_pkg::OFF_IRQ_STAT) ?
                     pwdata[2:0] : 3'h0)) |
                    {ready_nxt ^ ready_d_r, warn_s & ~warn_d_r, alarm_s & ~alarm_d_r};
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule

// *** servo_status_props.sv ***
// Purpose: timing checks on contacts and bus answers
// Assumes: checks pause while clk_en is low
// Notes: bound from the bench top file
`timescale 1ns/1ps
module servo_status_props
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_ok,
  input wire logic base_shutoff,
  input wire logic alarm_active,
  input wire logic warning_active,
  input wire logic trouble_out,
  input wire logic ready_out,
  input wire logic brake_interlock_out,
  input wire logic warning_out,
  input wire logic alarm_group_bit0,
  input wire logic alarm_group_bit1,
  input wire logic alarm_group_bit2
);
  default clocking cb @(posedge pclk); endclocking
  // Frozen design ignores its pins, so checks pause with the clock enable
  default disable iff (!presetn || !clk_en);
  logic [2:0] code;
  assign code = {alarm_group_bit2, alarm_group_bit1, alarm_group_bit0};
  // ****
  // Properties
  // ****
  sequence s_setup;
    psel && !penable;
  endsequence
  // Five cycles covers sync plus output flop
  sequence s_alarm_on;
    alarm_active [*5];
  endsequence
  a_zero_wait: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  a_single_ready: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready && penable)
    else $error("error outside access");
  a_trouble_opens: assert property ((!power_ok || base_shutoff) [*5] |-> !trouble_out)
    else $error("trouble closed without power");
  a_alarm_trouble: assert property (s_alarm_on |-> !trouble_out)
    else $error("trouble closed during alarm");
  a_alarm_ready: assert property (s_alarm_on |-> !ready_out)
    else $error("ready closed during alarm");
  a_alarm_brake: assert property (s_alarm_on |-> !brake_interlock_out)
    else $error("brake closed during alarm");
  a_warn_idle: assert property (!warning_active [*5] |-> !warning_out)
    else $error("warning closed without cause");
  a_code_held: assert property ($fell(|code) |-> $past(psel, 2) || $past(psel, 3))
    else $error("code dropped without write");
endmodule

// *** host_contact_reader.sv ***
// Purpose: host side scan of the status contacts
// Assumes: contacts read once per clock
// Notes: seen bit order trouble first, interrupt last
`timescale 1ns/1ps
module host_contact_reader
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trouble_out,
  input wire logic ready_out,
  input wire logic in_position_out,
  input wire logic speed_reached_out,
  input wire logic zero_speed_out,
  input wire logic brake_interlock_out,
  input wire logic warning_out,
  input wire logic alarm_group_bit0,
  input wire logic alarm_group_bit1,
  input wire logic alarm_group_bit2,
  input wire logic irq,
  output logic [10:0] seen
);
  // Scan adds one cycle, like a real input filter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seen <= 11'h000;
    else
      seen <= {irq, alarm_group_bit2, alarm_group_bit1, alarm_group_bit0, warning_out,
               brake_interlock_out, zero_speed_out, speed_reached_out, in_position_out,
               ready_out, trouble_out};
  end
endmodule

// *** servo_status_outputs_tb_top.sv ***
// Purpose: self-checking bench for the status contacts
// Assumes: short startup count of 20 cycles
// Notes: contacts judged through the host scan
`timescale 1ns/1ps
module servo_status_outputs_tb_top;
  localparam logic [10:0] TRB = 11'h001, RDY = 11'h002, POS = 11'h004, SPD = 11'h008;
  localparam logic [10:0] ZRO = 11'h010, BRK = 11'h020, WRN = 11'h040, GRP = 11'h380;
  localparam logic [10:0] IRQ = 11'h400;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, alarm_num = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic power_ok = 1'b1, base_shutoff = 1'b0, alarm_active = 1'b0, warning_active = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] droop_abs = 16'h0, motor_speed = 16'h0, preset_speed = 16'h0;
  logic trouble_out, ready_out, in_position_out, speed_reached_out, zero_speed_out;
  logic brake_interlock_out, warning_out, alarm_group_bit0, alarm_group_bit1;
  logic alarm_group_bit2, irq;
  logic [10:0] seen;
  int err_total = 0;
  int comparisons = 0;
  always #4 pclk = ~pclk;
  servo_status_outputs #(.STARTUP_CYC(20)) DUT (.pclk, .presetn, .clk_en, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .power_ok,
    .base_shutoff, .alarm_active, .alarm_num, .warning_active, .droop_abs, .motor_speed,
    .preset_speed, .trouble_out, .ready_out, .in_position_out, .speed_reached_out,
    .zero_speed_out, .brake_interlock_out, .warning_out, .alarm_group_bit0,
    .alarm_group_bit1, .alarm_group_bit2, .irq);
  host_contact_reader host (.pclk, .presetn, .trouble_out, .ready_out, .in_position_out,
    .speed_reached_out, .zero_speed_out, .brake_interlock_out, .warning_out,
    .alarm_group_bit0, .alarm_group_bit1, .alarm_group_bit2, .irq, .seen);
  // ****
  // Shared tasks
  // ****
  task automatic wrap_up();
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Sample at the falling edge so registered outputs have settled
  task automatic chk(input logic [10:0] m, input logic [10:0] e);
    @(negedge pclk);
    cmp({21'h0, seen & m}, {21'h0, e});
    @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is judged at the rising edge, where the slave samples it too
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      err_total++;
      $display("FAIL %0t no bus answer", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps the next call from reassigning psel in this step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (6) @(posedge pclk);
  endtask
  task automatic pins();
    repeat (6) @(posedge pclk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_startup();
    chk(TRB | WRN, 11'h000);
    repeat (30) @(posedge pclk);
    chk(TRB, TRB);
    base_shutoff <= 1'b1;
    pins();
    chk(TRB, 11'h000);
    base_shutoff <= 1'b0;
    power_ok <= 1'b0;
    pins();
    chk(TRB, 11'h000);
    power_ok <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(TRB, TRB);
  endtask
  task automatic t_regs();
    apb(1'b0, servo_status_pkg::OFF_CFG, 32'h0);
    cmp(rd, 32'h0032_0064);
    apb(1'b0, 8'h1C, 32'h0);
    cmp({31'h0, er}, 32'h1);
    apb(1'b1, servo_status_pkg::OFF_IRQ_MASK, 32'h1);
    apb(1'b0, servo_status_pkg::OFF_IRQ_MASK, 32'h0);
    cmp(rd, 32'h1);
  endtask
  task automatic t_ready_pos();
    wr(servo_status_pkg::OFF_CTRL, 32'h1);
    chk(RDY | BRK, RDY | BRK);
    wr(servo_status_pkg::OFF_CTRL, 32'h0);
    chk(RDY | BRK, 11'h000);
    droop_abs <= 16'h0064;
    wr(servo_status_pkg::OFF_CTRL, 32'h3);
    chk(POS, POS);
    droop_abs <= 16'h0065;
    pins();
    chk(POS, 11'h000);
  endtask
  task automatic t_speed();
    preset_speed <= 16'h03E8;
    motor_speed <= 16'h03E5;
    wr(servo_status_pkg::OFF_CTRL, 32'h1);
    chk(SPD | ZRO, SPD);
    motor_speed <= 16'h01F4;
    pins();
    chk(SPD, 11'h000);
    preset_speed <= 16'h0032;
    pins();
    chk(SPD, SPD);
    motor_speed <= 16'h0032;
    pins();
    chk(ZRO, ZRO);
    motor_speed <= 16'h0033;
    pins();
    chk(ZRO, 11'h000);
    wr(servo_status_pkg::OFF_CFG, 32'h0064_0064);
    chk(ZRO, ZRO);
  endtask
  task automatic t_brake();
    motor_speed <= 16'h0000;
    wr(servo_status_pkg::OFF_CTRL, 32'h5);
    chk(ZRO | BRK, ZRO | BRK);
    alarm_num <= 8'hFF;
    alarm_active <= 1'b1;
    pins();
    chk(ZRO | BRK | TRB, 11'h000);
    alarm_active <= 1'b0;
    wr(servo_status_pkg::OFF_CTRL, 32'h24);
    chk(ZRO | BRK, 11'h000);
  endtask
  task automatic t_alarm();
    wr(servo_status_pkg::OFF_IRQ_STAT, 32'h7);
    wr(servo_status_pkg::OFF_CTRL, 32'h11);
    alarm_num <= 8'h33;
    alarm_active <= 1'b1;
    pins();
    chk(GRP | IRQ | TRB | ZRO, 11'h480);
    alarm_active <= 1'b0;
    pins();
    chk(GRP | ZRO, 11'h080);
    wr(servo_status_pkg::OFF_IRQ_STAT, 32'h1);
    chk(IRQ, 11'h000);
    wr(servo_status_pkg::OFF_CTRL, 32'h31);
    chk(GRP | RDY | ZRO, RDY | ZRO);
  endtask
  task automatic t_warn();
    wr(servo_status_pkg::OFF_CTRL, 32'h9);
    warning_active <= 1'b1;
    pins();
    chk(WRN | RDY | IRQ, WRN);
    warning_active <= 1'b0;
    pins();
    chk(WRN | RDY, 11'h000);
  endtask
  // Clock enable low must freeze the pin path, so a power drop goes unseen
  task automatic t_freeze();
    clk_en <= 1'b0;
    power_ok <= 1'b0;
    pins();
    chk(TRB, TRB);
    clk_en <= 1'b1;
    power_ok <= 1'b1;
    pins();
    chk(TRB, TRB);
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_startup();
    t_freeze();
    t_regs();
    t_ready_pos();
    t_speed();
    t_brake();
    t_alarm();
    t_warn();
    wrap_up();
  end
  // Whole run is a few hundred cycles
  initial
  begin
    #(8 * 20000);
    err_total++;
    $display("FAIL %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
bind servo_status_outputs servo_status_props chk_i (.pclk, .presetn, .clk_en, .psel, .penable,
  .pready, .pslverr, .power_ok, .base_shutoff, .alarm_active, .warning_active,
  .trouble_out, .ready_out, .brake_interlock_out, .warning_out, .alarm_group_bit0,
  .alarm_group_bit1, .alarm_group_bit2);
